// ### verilog/iacl_engine.sv
// Ingress access control filter engine with its AXI4-Lite table port.
// Behaviour
// - Sixteen-entry ordered table per port.
// - Match ingress L2, L3 and L4 header fields.
// - Decision may override normal forwarding results.
// - Selected action sets forwarding and priority.
// - Watchdog flags missing frame within interval.
// - Event counter flags after programmed frame count.
// - Counting entries hold 11-bit count, no action.
// - Counting rule pairs with same-index action.
// - Processing entry ANDs selected matching rules.
// - Four-bit pointer names the action rule.
// - Entries sharing a pointer are ORed.
// - All rules evaluated; entry zero first.
// - One action; lowest pointer value wins.
// - Layer zero disables the matching rule.
// - Layer one selects MAC, type or count.
// - Layer two selects masked or full IPv4.
// - Layer three selects protocol, ports, sequence.
// - Time-unit bit picks microseconds or milliseconds.
// - Watchdog loads counter, decrements, flags expiry.
// - Event mode increments; flags terminal and clears on the same edge.
// - Polarity and direction bits shape comparison.
`timescale 1ns/1ns
module iacl_engine (
  input  wire logic                     CORE_CLK_I,
  input  wire logic                     RST_I,
  input  wire iacl_pkg::iacl_hdr_t      HDR_I,
  output iacl_pkg::iacl_dec_t           DEC_O,
  output logic [iacl_pkg::ENTRIES-1:0]  COUNT_EVENT_O,
  input  wire logic                     AXI_AWVALID_I,
  output logic                          AXI_AWREADY_O,
  input  wire logic [iacl_pkg::ADDR_W-1:0] AXI_AWADDR_I,
  input  wire logic                     AXI_WVALID_I,
  output logic                          AXI_WREADY_O,
  input  wire logic [31:0]              AXI_WDATA_I,
  input  wire logic [3:0]               AXI_WSTRB_I,
  output logic                          AXI_BVALID_O,
  input  wire logic                     AXI_BREADY_I,
  output logic [1:0]                    AXI_BRESP_O,
  input  wire logic                     AXI_ARVALID_I,
  output logic                          AXI_ARREADY_O,
  input  wire logic [iacl_pkg::ADDR_W-1:0] AXI_ARADDR_I,
  output logic                          AXI_RVALID_O,
  input  wire logic                     AXI_RREADY_I,
  output logic [31:0]                   AXI_RDATA_O,
  output logic [1:0]                    AXI_RRESP_O
);
  import iacl_pkg::*;

  function automatic logic entry_hit(input logic [ADDR_W-1:0] a);
    entry_hit = (a[11:9] == 3'h0) && (a[4:2] < 3'(WORDS));
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      o[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
    wmerge = o;
  endfunction

  // ----------------------------------------------------------------
  // Table storage and AXI4-Lite write side
  // ----------------------------------------------------------------
  // per-port table.
  logic [31:0]       tbl_r [ENTRIES][WORDS];
  logic              aw_full_r;
  logic              w_full_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  wire               do_wr  = aw_full_r && w_full_r && !bvalid_r;
  wire               wr_ok  = entry_hit(awaddr_r);
  wire               wr_st  = awaddr_r[11:2] == STATUS_ADDR[11:2];
  wire [3:0]         wr_ent = awaddr_r[8:5];
  wire [2:0]         wr_wd  = awaddr_r[4:2];

  assign AXI_AWREADY_O = !aw_full_r && !bvalid_r;
  assign AXI_WREADY_O  = !w_full_r && !bvalid_r;
  assign AXI_BVALID_O  = bvalid_r;
  assign AXI_BRESP_O   = bresp_r;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= REG_RESET;
      wstrb_r   <= 4'h0;
    end else begin
      if (AXI_AWVALID_I && AXI_AWREADY_O) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= AXI_AWADDR_I;
      end
      if (AXI_WVALID_I && AXI_WREADY_O) begin
        w_full_r <= 1'b1;
        wdata_r  <= AXI_WDATA_I;
        wstrb_r  <= AXI_WSTRB_I;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (wr_ok || wr_st) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && AXI_BREADY_I) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int e = 0; e < ENTRIES; e++) begin
        for (int w = 0; w < WORDS; w++) begin
          tbl_r[e][w] <= REG_RESET;
        end
      end
    end else if (do_wr && wr_ok) begin
      tbl_r[wr_ent][wr_wd] <= wmerge(tbl_r[wr_ent][wr_wd], wdata_r, wstrb_r);
    end
  end

  // ----------------------------------------------------------------
  // Time base for watchdog counting
  // ----------------------------------------------------------------
  localparam int US_W = $clog2(US_CYCLES);
  localparam int MS_W = $clog2(MS_US);
  logic [US_W-1:0] us_div_r;
  logic [MS_W-1:0] ms_div_r;
  wire             us_tick = us_div_r == US_W'(US_CYCLES - 1);
  wire             ms_tick = us_tick && (ms_div_r == MS_W'(MS_US - 1));

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      us_div_r <= '0;
      ms_div_r <= '0;
    end else begin
      us_div_r <= us_tick ? '0 : us_div_r + US_W'(1);
      if (us_tick) begin
        ms_div_r <= ms_tick ? '0 : ms_div_r + MS_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Matching rules and their counters
  // ----------------------------------------------------------------
  logic [ENTRIES-1:0] match_w;
  logic [ENTRIES-1:0] cnt_mode_w;
  logic [ENTRIES-1:0] pe_true_w;
  logic [3:0]         ptr_w [ENTRIES];

  for (genvar g = 0; g < ENTRIES; g++) begin : g_rule
    wire [31:0] ctl   = tbl_r[g][W_CTRL];
    wire [31:0] lo    = tbl_r[g][W_VLO];
    wire [31:0] hi    = tbl_r[g][W_VHI];
    wire [31:0] act   = tbl_r[g][W_ACT];
    wire [31:0] prc   = tbl_r[g][W_PROC];
    wire [1:0]  lay   = ctl[1:0];
    wire [1:0]  msel  = ctl[CTRL_SEL_LSB +: 2];
    wire        dir   = ctl[CTRL_DIR_BIT];
    wire        pol   = ctl[CTRL_POL_BIT];
    wire [47:0] mac   = dir ? HDR_I.mac_sa : HDR_I.mac_da;
    wire [31:0] ip    = dir ? HDR_I.ip_sa : HDR_I.ip_da;
    wire [15:0] port  = dir ? HDR_I.l4_sport : HDR_I.l4_dport;
    wire        mac_eq = mac == {hi[15:0], lo};
    wire        typ_eq = HDR_I.ethertype == hi[31:16];
    wire        ipm_eq = ((ip ^ lo) & ~hi) == 32'h0000_0000;
    wire        ipb_eq = (HDR_I.ip_sa == lo) && (HDR_I.ip_da == hi);
    logic       use_w;
    logic       eq_w;
    logic [10:0] cnt_r;
    logic        ev_r;

    always_comb begin
      use_w = 1'b1;
      eq_w  = 1'b0;
      case (lay)
        LAYER_L2: begin
          case (msel)
            2'h0:    use_w = 1'b0;
            2'h1:    eq_w = typ_eq;
            2'h2:    eq_w = mac_eq;
            default: eq_w = mac_eq && typ_eq;
          endcase
        end
        LAYER_L3: begin
          use_w = HDR_I.is_ipv4 && (msel == 2'h1 || msel == 2'h2);
          eq_w  = (msel == 2'h1) ? ipm_eq : ipb_eq;
        end
        LAYER_L4: begin
          case (msel)
            2'h0: begin
              use_w = HDR_I.is_ipv4;
              eq_w  = HDR_I.ip_proto == lo[7:0];
            end
            2'h1: begin
              use_w = HDR_I.is_tcp;
              eq_w  = port == lo[15:0];
            end
            2'h2: begin
              use_w = HDR_I.is_udp;
              eq_w  = port == lo[15:0];
            end
            default: begin
              use_w = HDR_I.is_tcp;
              eq_w  = HDR_I.tcp_seq == lo;
            end
          endcase
        end
        default: use_w = 1'b0;
      endcase
    end

    // polarity selects equal or not equal.
    assign match_w[g]    = use_w && (pol ? eq_w : !eq_w);
    assign cnt_mode_w[g] = (lay == LAYER_L2) && (msel == 2'h0);
    assign pe_true_w[g]  = (prc[15:0] != 16'h0000) &&
                           ((match_w & prc[15:0]) == prc[15:0]);
    assign ptr_w[g]      = prc[19:16];
    assign COUNT_EVENT_O[g] = ev_r;

    wire [10:0] cval    = act[10:0];
    wire        cnt_hit = HDR_I.valid && cnt_mode_w[g] && mac_eq && typ_eq;
    wire        tick    = act[ACT_UNIT_BIT] ? ms_tick : us_tick;

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
        cnt_r <= 11'h000;
        ev_r  <= 1'b0;
      end else begin
        ev_r <= 1'b0;
        if (!cnt_mode_w[g]) begin
          cnt_r <= 11'h000;
        end else if (act[ACT_ALGO_BIT]) begin
          if (cnt_hit) begin
            if (cnt_r + 11'h001 >= cval) begin
              cnt_r <= 11'h000;
              ev_r  <= 1'b1;
            end else begin
              cnt_r <= cnt_r + 11'h001;
            end
          end
        end else if (cnt_hit) begin
          cnt_r <= cval;
        end else if (tick && cnt_r != 11'h000) begin
          cnt_r <= cnt_r - 11'h001;
          ev_r  <= cnt_r == 11'h001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Processing entries and action selection
  // ----------------------------------------------------------------
  logic [ENTRIES-1:0] act_hit_w;
  logic [3:0]         sel_w;
  logic               found_w;
  wire [ENTRIES-1:0]  act_ok_w = act_hit_w & ~cnt_mode_w;
  wire [31:0]         sel_act  = tbl_r[sel_w][W_ACT];

  always_comb begin
    act_hit_w = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (pe_true_w[i]) begin
        act_hit_w[ptr_w[i]] = 1'b1;
      end
    end
  end

  always_comb begin
    sel_w   = 4'h0;
    found_w = 1'b0;
    for (int k = ENTRIES - 1; k >= 0; k--) begin
      if (act_ok_w[k]) begin
        sel_w   = 4'(k);
        found_w = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Decision output and status
  // ----------------------------------------------------------------
  iacl_dec_t   dec_r;
  logic        last_hit_r;
  logic [3:0]  last_ptr_r;
  logic [15:0] hit_cnt_r;
  assign DEC_O = dec_r;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dec_r      <= '0;
      last_hit_r <= 1'b0;
      last_ptr_r <= 4'h0;
      hit_cnt_r  <= 16'h0000;
    end else begin
      dec_r.valid <= HDR_I.valid;
      dec_r.hit     <= HDR_I.valid && found_w;
      dec_r.pointer <= sel_w;
      dec_r.fwd_mode <= sel_act[1:0];
      dec_r.prio     <= sel_act[ACT_PRIO_LSB +: 3];
      dec_r.port_map <= sel_act[ACT_PORT_LSB +: 6];
      if (HDR_I.valid) begin
        last_hit_r <= found_w;
        last_ptr_r <= sel_w;
        if (found_w) begin
          hit_cnt_r <= hit_cnt_r + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read side
  // ----------------------------------------------------------------
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  wire [ADDR_W-1:0]  ar     = AXI_ARADDR_I;
  wire               rd_ok  = entry_hit(ar);
  wire               rd_st  = ar[11:2] == STATUS_ADDR[11:2];
  wire [31:0]        status = {hit_cnt_r, 8'h00, last_ptr_r, 3'h0, last_hit_r};
  wire [31:0]        rd_dat = rd_ok ? tbl_r[ar[8:5]][ar[4:2]] :
                              rd_st ? status : 32'h0000_0000;
  assign AXI_ARREADY_O = !rvalid_r;
  assign AXI_RVALID_O  = rvalid_r;
  assign AXI_RDATA_O   = rdata_r;
  assign AXI_RRESP_O   = rresp_r;

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (AXI_ARVALID_I && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_dat;
      rresp_r  <= (rd_ok || rd_st) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && AXI_RREADY_I) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  a_decision_latency: assert property (
    HDR_I.valid |=> DEC_O.valid) else $error("decision missing after header");
  a_no_entry_idle: assert property (
    HDR_I.valid && act_ok_w == '0 |=> !DEC_O.hit) else $error("hit without true entry");
  a_lowest_wins: assert property (
    HDR_I.valid && act_ok_w[0] |=> DEC_O.hit && DEC_O.pointer == 4'h0)
    else $error("action zero not chosen");
  a_entry_pointer: assert property (
    HDR_I.valid && pe_true_w[0] && !cnt_mode_w[ptr_w[0]]
    |=> DEC_O.hit && DEC_O.pointer <= $past(ptr_w[0])) else $error("pointer not honoured");
  a_disabled_rule: assert property (
    tbl_r[0][W_CTRL][1:0] == LAYER_OFF |-> !match_w[0]) else $error("disabled rule matched");
  a_count_no_act: assert property (
    HDR_I.valid && cnt_mode_w[3] |=> !(DEC_O.hit && DEC_O.pointer == 4'h3))
    else $error("counting entry took an action");
  a_event_clears: assert property (
    COUNT_EVENT_O[3] && tbl_r[3][W_ACT][ACT_ALGO_BIT] |-> g_rule[3].cnt_r == 11'h000)
    else $error("event count not cleared");
  a_watchdog_fire: assert property (
    cnt_mode_w[3] && !tbl_r[3][W_ACT][ACT_ALGO_BIT] && g_rule[3].cnt_r == 11'h001 &&
    g_rule[3].tick && !g_rule[3].cnt_hit |=> COUNT_EVENT_O[3])
    else $error("watchdog expiry not flagged");
  a_write_response: assert property (
    do_wr |=> AXI_BVALID_O && (!$past(wr_ok && &wstrb_r) || tbl_r[wr_ent][wr_wd] == wdata_r))
    else $error("write response missing");
  a_us_period: assert property (
    us_tick |=> !us_tick [*8]) else $error("microsecond tick too fast");

  c_frame_hit: cover property (HDR_I.valid ##1 DEC_O.hit);
  c_count_event: cover property (COUNT_EVENT_O != '0);
  c_write_then_frame: cover property (do_wr ##1 HDR_I.valid);
  c_read_status: cover property (AXI_ARVALID_I && rd_st);
endmodule

// ### verilog/iacl_pkg.sv
// Constants and carrier types for the ingress access control filter engine.
package iacl_pkg;
  // ----------------------------------------------------------------
  // Table geometry and register map
  // ----------------------------------------------------------------
  localparam int          ENTRIES     = 16;
  localparam int          WORDS       = 5;
  localparam int          ADDR_W      = 12;
  localparam logic [2:0]  W_CTRL      = 3'h0;
  localparam logic [2:0]  W_VLO       = 3'h1;
  localparam logic [2:0]  W_VHI       = 3'h2;
  localparam logic [2:0]  W_ACT       = 3'h3;
  localparam logic [2:0]  W_PROC      = 3'h4;
  localparam logic [11:0] STATUS_ADDR = 12'h0200;
  localparam logic [31:0] REG_RESET   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SEL_LSB = 2;
  localparam int CTRL_DIR_BIT = 4;
  localparam int CTRL_POL_BIT = 5;
  localparam int ACT_PRIO_LSB = 2;
  localparam int ACT_PORT_LSB = 5;
  localparam int ACT_UNIT_BIT = 11;
  localparam int ACT_ALGO_BIT = 12;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
  localparam int MS_US         = 1000;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LAYER_OFF = 2'h0,
    LAYER_L2  = 2'h1,
    LAYER_L3  = 2'h2,
    LAYER_L4  = 2'h3
  } iacl_layer_t;
  typedef struct packed {
    logic        valid;
    logic [47:0] mac_da;
    logic [47:0] mac_sa;
    logic [15:0] ethertype;
    logic        is_ipv4;
    logic [31:0] ip_sa;
    logic [31:0] ip_da;
    logic [7:0]  ip_proto;
    logic        is_tcp;
    logic        is_udp;
    logic [15:0] l4_sport;
    logic [15:0] l4_dport;
    logic [31:0] tcp_seq;
  } iacl_hdr_t;
  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [3:0] pointer;
    logic [1:0] fwd_mode;
    logic [2:0] prio;
    logic [5:0] port_map;
  } iacl_dec_t;
endpackage

// ### testbench/iacl_fabric_model.sv
// Header source that stands in for the ingress parser in front of the filter.
`timescale 1ns/1ns
module iacl_fabric_model (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                send_i,
  input  wire iacl_pkg::iacl_hdr_t frame_i,
  output iacl_pkg::iacl_hdr_t      hdr_o
);
  import iacl_pkg::*;
  localparam int HW = $bits(iacl_hdr_t);
  // Between frames valid is low and every other field toggles, so a stale header can never pass for a match.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hdr_o <= '0;
    end else if (send_i) begin
      hdr_o <= {1'b1, frame_i[HW-2:0]};
    end else begin
      hdr_o <= {1'b0, ~hdr_o[HW-2:0]};
    end
  end
endmodule

// ### testbench/tb_iacl_engine.sv
// Self-checking bench for the ingress access control filter engine.
`timescale 1ns/1ns
module tb_iacl_engine;
  import iacl_pkg::*;
  logic              clk, rst, awv, wv, bre, arv, rre, send;
  logic              aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0]       wd, rd;
  logic [1:0]        br, rr;
  logic [ENTRIES-1:0] cev;
  iacl_hdr_t         fr, hdr;
  iacl_dec_t         dec;
  int                failures, total_checks, ev_cnt, base, i;
  // Thirteen rule cases over layer, selection, polarity and direction: control, value low, value high.
  localparam logic [31:0] ROWS [13][3] = '{
    '{32'h25, 32'h0, 32'h0800_0000}, '{32'h29, 32'h2233_4455, 32'h11},
    '{32'h2D, 32'h2233_4455, 32'h0800_0011}, '{32'h39, 32'h7788_99AA, 32'h66},
    '{32'h09, 32'h2233_4455, 32'h11}, '{32'h09, 32'h0, 32'h11},
    '{32'h26, 32'hC0A8_00FF, 32'hFF}, '{32'h2A, 32'h0A00_0001, 32'hC0A8_0001},
    '{32'h23, 32'h06, 32'h0}, '{32'h27, 32'h50, 32'h0}, '{32'h2B, 32'h50, 32'h0},
    '{32'h2F, 32'h1234_5678, 32'h0}, '{32'h2C, 32'h1234_5678, 32'h0800_0011}};
  localparam logic [12:0] HITS = 13'h0BEF;

  iacl_fabric_model fab (.clk_i(clk), .rst_i(rst), .send_i(send), .frame_i(fr), .hdr_o(hdr));
  iacl_engine uut (
    .CORE_CLK_I(clk), .RST_I(rst), .HDR_I(hdr), .DEC_O(dec), .COUNT_EVENT_O(cev),
    .AXI_AWVALID_I(awv), .AXI_AWREADY_O(aw_rdy), .AXI_AWADDR_I(awa),
    .AXI_WVALID_I(wv), .AXI_WREADY_O(w_rdy), .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hF),
    .AXI_BVALID_O(b_vld), .AXI_BREADY_I(bre), .AXI_BRESP_O(br),
    .AXI_ARVALID_I(arv), .AXI_ARREADY_O(ar_rdy), .AXI_ARADDR_I(ara),
    .AXI_RVALID_O(r_vld), .AXI_RREADY_I(rre), .AXI_RDATA_O(rd), .AXI_RRESP_O(rr));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rst) ev_cnt <= 0;
    else if (cev[3] === 1'b1) ev_cnt <= ev_cnt + 1;
  end
  // ----------------------------------------------------------------
  // Bus, frame and compare tasks
  // ----------------------------------------------------------------
  function automatic logic [11:0] ad(input int e, input int w);
    return 12'(e * 32 + w * 4);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bre <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_rdy) awv <= 1'b0;
      if (w_rdy) wv <= 1'b0;
    end while (b_vld !== 1'b1);
    bre <= 1'b0;
    chk({30'h0, br}, {30'h0, e});
    @(posedge clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] e);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_rdy) arv <= 1'b0;
    end while (r_vld !== 1'b1);
    rre <= 1'b0;
    chk(rd, ed);
    chk({30'h0, rr}, {30'h0, e});
    @(posedge clk);
  endtask
  // The decision is looked at in the one cycle in which it stands.
  task automatic frm(input logic h, input logic [3:0] p, input logic [10:0] a);
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (2) @(posedge clk);
    chk({15'h0, dec.valid, dec.hit,
         h ? {dec.pointer, dec.port_map, dec.prio, dec.fwd_mode} : 15'h0},
        {15'h0, 1'b1, h, h ? {p, a} : 15'h0});
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, awv, wv, bre, arv, rre, send} = 7'b100_0000;
    {awa, ara, wd} = '0;
    fr = '{1'b1, 48'h0011_2233_4455, 48'h0066_7788_99AA, 16'h0800, 1'b1, 32'h0A00_0001,
           32'hC0A8_0001, 8'h06, 1'b1, 1'b0, 16'h1F90, 16'h0050, 32'h1234_5678};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(ad(0, 0), REG_RESET, RESP_OKAY);
    rdc(12'h400, 32'h0, RESP_SLVERR);
    wr(12'h400, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ad(0, 3), 32'h54E, RESP_OKAY);
    wr(ad(0, 4), 32'h1, RESP_OKAY);
    for (i = 0; i < 13; i++) begin
      wr(ad(0, 0), ROWS[i][0], RESP_OKAY);
      wr(ad(0, 1), ROWS[i][1], RESP_OKAY);
      wr(ad(0, 2), ROWS[i][2], RESP_OKAY);
      frm(HITS[i], 4'h0, 11'h54E);
    end
    // Entry 15 holds the first rule and the lowest-priority action.
    wr(ad(0, 0), ROWS[1][0], RESP_OKAY);
    wr(ad(0, 1), ROWS[1][1], RESP_OKAY);
    wr(ad(0, 2), ROWS[1][2], RESP_OKAY);
    wr(ad(15, 0), 32'h25, RESP_OKAY);
    wr(ad(15, 2), 32'h0800_0000, RESP_OKAY);
    wr(ad(15, 3), 32'h7FF, RESP_OKAY);
    wr(ad(0, 4), 32'h8001, RESP_OKAY);
    wr(ad(1, 4), 32'hF_8000, RESP_OKAY);
    wr(ad(2, 4), 32'hF_0001, RESP_OKAY);
    rdc(ad(15, 3), 32'h7FF, RESP_OKAY);
    frm(1'b1, 4'h0, 11'h54E);
    wr(ad(15, 0), 32'h0, RESP_OKAY);
    frm(1'b1, 4'hF, 11'h7FF);
    rdc(STATUS_ADDR, 32'h000C_00F1, RESP_OKAY);
    wr(ad(0, 0), 32'h0, RESP_OKAY);
    frm(1'b0, 4'h0, 11'h0);
    wr(ad(3, 0), 32'h1, RESP_OKAY);
    wr(ad(3, 1), 32'h2233_4455, RESP_OKAY);
    wr(ad(3, 2), 32'h0800_0011, RESP_OKAY);
    wr(ad(3, 3), 32'h1003, RESP_OKAY);
    wr(ad(3, 4), 32'h3_0008, RESP_OKAY);
    for (i = 1; i <= 6; i++) begin
      frm(1'b0, 4'h0, 11'h0);
      repeat (3) @(posedge clk);
      chk(32'(ev_cnt), 32'(i / 3));
    end
    wr(ad(3, 3), 32'h4, RESP_OKAY);
    base = ev_cnt;
    frm(1'b0, 4'h0, 11'h0);
    repeat (60) @(posedge clk);
    frm(1'b0, 4'h0, 11'h0);
    repeat (60) @(posedge clk);
    chk(32'(ev_cnt), 32'(base));
    repeat (60) @(posedge clk);
    chk(32'(ev_cnt), 32'(base + 1));
    repeat (200) @(posedge clk);
    chk(32'(ev_cnt), 32'(base + 1));
    wr(ad(3, 3), 32'h801, RESP_OKAY);
    frm(1'b0, 4'h0, 11'h0);
    repeat (2000) @(posedge clk);
    chk(32'(ev_cnt), 32'(base + 1));
    report_and_stop();
  end
endmodule
